// >>> rtl/vmp_pkg.sv
// Package with register map, field layout and timing constants of the master/power bank.
package vmp_pkg;

    // Register byte offsets on the control port.
    localparam logic [7:0] ADDR_CFG2      = 8'h0c;
    localparam logic [7:0] ADDR_CHAN_PD   = 8'h0d;
    localparam logic [7:0] ADDR_GLOBAL_PD = 8'h0e;
    localparam logic [7:0] ADDR_HOLD      = 8'h0f;
    localparam logic [7:0] ADDR_M1_SEL    = 8'h10;
    localparam logic [7:0] ADDR_M1_LEVEL  = 8'h11;
    localparam logic [7:0] ADDR_M1_CTRL   = 8'h12;
    localparam logic [7:0] ADDR_M2_SEL    = 8'h13;
    localparam logic [7:0] ADDR_M2_LEVEL  = 8'h14;

    // Reset values.
    localparam logic [7:0] RST_CFG2       = 8'h0d;
    localparam logic [7:0] RST_CHAN_PD    = 8'h00;
    localparam logic [7:0] RST_GLOBAL_PD  = 8'h01;
    localparam logic [7:0] RST_HOLD       = 8'h00;
    localparam logic [7:0] RST_SEL        = 8'hff;
    localparam logic [7:0] RST_LEVEL      = 8'hd2;
    localparam logic [7:0] RST_M1_CTRL    = 8'h00;

    // Implemented-bit masks; every other bit is reserved and reads zero.
    localparam logic [7:0] MASK_CFG2      = 8'h1f;
    localparam logic [7:0] MASK_GLOBAL_PD = 8'h01;
    localparam logic [7:0] MASK_HOLD      = 8'h80;
    localparam logic [7:0] MASK_M1_CTRL   = 8'h03;

    // Field positions.
    localparam int ZC_LSB      = 0;
    localparam int TO_LSB      = 2;
    localparam int GPD_BIT     = 0;
    localparam int HOLD_BIT    = 7;
    localparam int SILENCE_BIT = 1;
    localparam int QTR_BIT     = 0;

    // Level arithmetic in quarter-dB units: code*2 minus twice the zero-dB code.
    localparam logic [11:0] LEVEL_ZERO_Q = 12'h1a4;
    localparam logic signed [9:0] GAIN_MAX_Q = 10'sh058;
    localparam logic signed [9:0] GAIN_MIN_Q = -10'sh180;

    // Timing.
    localparam int CLK_HZ     = 25_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // Zero-crossing update modes.
    typedef enum logic [1:0] {
        ZC_IMMEDIATE = 2'b00,
        ZC_DISCARD   = 2'b01,
        ZC_FLUSH     = 2'b10,
        ZC_RESERVED  = 2'b11
    } vmp_zc_mode_t;

    // Control set that the logic acts upon.
    typedef struct packed {
        logic [1:0] zc_mode_sel;
        logic [2:0] timeout_sel;
        logic [7:0] chan_pd;
        logic       global_pd;
        logic [7:0] m1_sel;
        logic [7:0] m1_level;
        logic       m1_silence;
        logic       m1_quarter;
        logic [7:0] m2_sel;
        logic [7:0] m2_level;
    } vmp_ctrl_t;

    // Time-out period in milliseconds for each selector code.
    function automatic int timeout_ms(input logic [2:0] sel);
        int ms;
        ms = 5;
        unique case (sel)
            3'h0: ms = 5;
            3'h1: ms = 10;
            3'h2: ms = 15;
            3'h3: ms = 18;
            3'h4: ms = 20;
            3'h5: ms = 30;
            3'h6: ms = 40;
            3'h7: ms = 50;
        endcase
        return ms;
    endfunction

endpackage

// >>> rtl/vmp_bank.sv
// Master volume, power-down and update-hold register bank with per-channel level scheduling.
// Notes on behaviour
// (R1) Mode 00 applies new levels immediately.
// (R2) Modes 01/10 apply on zero-cross or time-out.
// (R3) Mode 01: new value discards pending, restarts.
// (R4) Mode 10: new value flushes pending, restarts.
// (R5) Mode field bits 1:0, reset 01, 11 reserved.
// (R6) Channel power-down bits, reset zero, per channel.
// (R7) Global power-down bit 0, resets to one.
// (R8) Registers stay accessible during global power-down.
// (R9) Hold bit stores writes, releases together.
// (R10) Host sets hold, writes, then clears.
// (R11) Channel-select ones follow group, reset all ones.
// (R12) Master level steers selected channels, half-dB.
// (R13) Level code is twice dB plus 210.
// (R14) Out-of-range codes accepted, result clamped.
// (R15) Master one silence bit mutes selected channels.
// (R16) Master one quarter bit adds quarter dB.
// (R17) Time-out selector picks 5..50 ms, reset 011.
// (R18) Reserved bits read zero; levels sum then clamp.
`timescale 1ns/1ps

module vmp_bank #(
    parameter int NUM_CH      = 8,
    parameter int P_CYC_PER_MS = vmp_pkg::CYC_PER_MS
) (
    // Clock and reset.
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    // Register access from the control port.
    input  wire logic                   i_wr_en,
    input  wire logic                   i_rd_en,
    input  wire logic [7:0]             i_addr,
    input  wire logic [7:0]             i_wr_data,
    output logic      [7:0]             o_rd_data,
    // Channel side.
    input  wire logic [NUM_CH-1:0][7:0] i_chan_level,
    input  wire logic [NUM_CH-1:0]      i_zero_cross,
    output wire logic [NUM_CH-1:0][9:0] o_chan_gain,
    output logic      [NUM_CH-1:0]      o_chan_mute,
    output logic      [NUM_CH-1:0]      o_chan_pd
);

    // The power-down and select registers hold one bit per channel, so only eight channels can be served.
    if (NUM_CH != 8 || P_CYC_PER_MS < 1) begin : g_param_check
        $error("vmp_bank: NUM_CH must be 8 and P_CYC_PER_MS at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [7:0] cfg2_reg;
    logic [7:0] chan_pd_reg;
    logic [7:0] global_pd_reg;
    logic [7:0] hold_reg;
    logic [7:0] m1_sel_reg;
    logic [7:0] m1_level_reg;
    logic [7:0] m1_ctrl_reg;
    logic [7:0] m2_sel_reg;
    logic [7:0] m2_level_reg;

    // Write strobes per register; reserved bits are masked on the way in.
    wire logic wr_cfg2   = i_wr_en && (i_addr == vmp_pkg::ADDR_CFG2);
    wire logic wr_chpd   = i_wr_en && (i_addr == vmp_pkg::ADDR_CHAN_PD);
    wire logic wr_gpd    = i_wr_en && (i_addr == vmp_pkg::ADDR_GLOBAL_PD);
    wire logic wr_hold   = i_wr_en && (i_addr == vmp_pkg::ADDR_HOLD);
    wire logic wr_m1sel  = i_wr_en && (i_addr == vmp_pkg::ADDR_M1_SEL);
    wire logic wr_m1lvl  = i_wr_en && (i_addr == vmp_pkg::ADDR_M1_LEVEL);
    wire logic wr_m1ctrl = i_wr_en && (i_addr == vmp_pkg::ADDR_M1_CTRL);
    wire logic wr_m2sel  = i_wr_en && (i_addr == vmp_pkg::ADDR_M2_SEL);
    wire logic wr_m2lvl  = i_wr_en && (i_addr == vmp_pkg::ADDR_M2_LEVEL);

    // Writes are taken whatever the power state, so software can set up before waking.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg2_reg      <= vmp_pkg::RST_CFG2; // R5 R17
            chan_pd_reg   <= vmp_pkg::RST_CHAN_PD; // R6
            global_pd_reg <= vmp_pkg::RST_GLOBAL_PD; // R7
            hold_reg      <= vmp_pkg::RST_HOLD; // R9
            m1_sel_reg    <= vmp_pkg::RST_SEL; // R11
            m1_level_reg  <= vmp_pkg::RST_LEVEL; // R13
            m1_ctrl_reg   <= vmp_pkg::RST_M1_CTRL; // R15 R16
            m2_sel_reg    <= vmp_pkg::RST_SEL; // R11
            m2_level_reg  <= vmp_pkg::RST_LEVEL;
        end else begin
            if (wr_cfg2)   cfg2_reg      <= i_wr_data & vmp_pkg::MASK_CFG2; // R18
            if (wr_chpd)   chan_pd_reg   <= i_wr_data;
            if (wr_gpd)    global_pd_reg <= i_wr_data & vmp_pkg::MASK_GLOBAL_PD; // R8
            if (wr_hold)   hold_reg      <= i_wr_data & vmp_pkg::MASK_HOLD;
            if (wr_m1sel)  m1_sel_reg    <= i_wr_data;
            if (wr_m1lvl)  m1_level_reg  <= i_wr_data; // R14
            if (wr_m1ctrl) m1_ctrl_reg   <= i_wr_data & vmp_pkg::MASK_M1_CTRL;
            if (wr_m2sel)  m2_sel_reg    <= i_wr_data;
            if (wr_m2lvl)  m2_level_reg  <= i_wr_data;
        end
    end

    // Read selection; unmapped offsets answer zero.
    logic [7:0] rd_next;
    always_comb begin
        rd_next = 8'h00;
        unique case (i_addr)
            vmp_pkg::ADDR_CFG2:      rd_next = cfg2_reg;
            vmp_pkg::ADDR_CHAN_PD:   rd_next = chan_pd_reg;
            vmp_pkg::ADDR_GLOBAL_PD: rd_next = global_pd_reg;
            vmp_pkg::ADDR_HOLD:      rd_next = hold_reg;
            vmp_pkg::ADDR_M1_SEL:    rd_next = m1_sel_reg;
            vmp_pkg::ADDR_M1_LEVEL:  rd_next = m1_level_reg;
            vmp_pkg::ADDR_M1_CTRL:   rd_next = m1_ctrl_reg;
            vmp_pkg::ADDR_M2_SEL:    rd_next = m2_sel_reg;
            vmp_pkg::ADDR_M2_LEVEL:  rd_next = m2_level_reg;
            default:                 rd_next = 8'h00;
        endcase
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 8'h00;
        end else if (i_rd_en) begin
            o_rd_data <= rd_next; // R8
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Update hold: the acting copy follows the registers only while hold is clear.

    vmp_pkg::vmp_ctrl_t ctrl_now;
    vmp_pkg::vmp_ctrl_t act_reg;
    wire logic          hold_on = hold_reg[vmp_pkg::HOLD_BIT];

    assign ctrl_now = '{
        zc_mode_sel: cfg2_reg[vmp_pkg::ZC_LSB +: 2],
        timeout_sel: cfg2_reg[vmp_pkg::TO_LSB +: 3],
        chan_pd:     chan_pd_reg,
        global_pd:   global_pd_reg[vmp_pkg::GPD_BIT],
        m1_sel:      m1_sel_reg,
        m1_level:    m1_level_reg,
        m1_silence:  m1_ctrl_reg[vmp_pkg::SILENCE_BIT],
        m1_quarter:  m1_ctrl_reg[vmp_pkg::QTR_BIT],
        m2_sel:      m2_sel_reg,
        m2_level:    m2_level_reg
    };

    // All held changes land in the same cycle, one edge after hold clears.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_reg <= '{
                zc_mode_sel: vmp_pkg::RST_CFG2[vmp_pkg::ZC_LSB +: 2],
                timeout_sel: vmp_pkg::RST_CFG2[vmp_pkg::TO_LSB +: 3],
                chan_pd:     vmp_pkg::RST_CHAN_PD,
                global_pd:   vmp_pkg::RST_GLOBAL_PD[vmp_pkg::GPD_BIT],
                m1_sel:      vmp_pkg::RST_SEL,
                m1_level:    vmp_pkg::RST_LEVEL,
                m1_silence:  vmp_pkg::RST_M1_CTRL[vmp_pkg::SILENCE_BIT],
                m1_quarter:  vmp_pkg::RST_M1_CTRL[vmp_pkg::QTR_BIT],
                m2_sel:      vmp_pkg::RST_SEL,
                m2_level:    vmp_pkg::RST_LEVEL
            };
        end else if (!hold_on) begin
            act_reg <= ctrl_now; // R9
        end
    end

    // Reserved mode code behaves as the discarding mode so a stray write stays glitch-free.
    wire logic mode_now_imm   = (act_reg.zc_mode_sel == vmp_pkg::ZC_IMMEDIATE); // R5
    wire logic mode_now_flush = (act_reg.zc_mode_sel == vmp_pkg::ZC_FLUSH);
    wire logic [31:0] to_limit =
        32'(vmp_pkg::timeout_ms(act_reg.timeout_sel) * P_CYC_PER_MS); // R17

    // Power and mute outputs.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_chan_pd   <= '1;
            o_chan_mute <= '0;
        end else begin
            o_chan_pd   <= act_reg.chan_pd | {NUM_CH{act_reg.global_pd}}; // R6 R7
            o_chan_mute <= act_reg.m1_sel & {NUM_CH{act_reg.m1_silence}}; // R11 R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel level target and zero-crossing scheduling.

    logic signed [9:0]  target   [NUM_CH];
    logic signed [9:0]  last_reg [NUM_CH];
    logic signed [9:0]  pend_reg [NUM_CH];
    logic signed [9:0]  gain_reg [NUM_CH];
    logic               wait_reg [NUM_CH];
    logic        [31:0] tmr_reg  [NUM_CH];

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        // Quarter-dB contributions; a master group counts only when it selects the channel.
        wire logic [11:0] own_q = {3'h0, i_chan_level[ch], 1'b0} - vmp_pkg::LEVEL_ZERO_Q;
        wire logic [11:0] m1_q  = act_reg.m1_sel[ch] ? // R11 R12 R13 R16
            ({3'h0, act_reg.m1_level, act_reg.m1_quarter} - vmp_pkg::LEVEL_ZERO_Q) : 12'h000;
        wire logic [11:0] m2_q  = act_reg.m2_sel[ch] ?
            ({3'h0, act_reg.m2_level, 1'b0} - vmp_pkg::LEVEL_ZERO_Q) : 12'h000;
        wire logic signed [11:0] sum_q = $signed(own_q + m1_q + m2_q); // R18
        wire logic signed [11:0] max_q = 12'(vmp_pkg::GAIN_MAX_Q);
        wire logic signed [11:0] min_q = 12'(vmp_pkg::GAIN_MIN_Q);
        wire logic new_val = (target[ch] != last_reg[ch]);
        wire logic expired = wait_reg[ch] && (tmr_reg[ch] >= to_limit - 32'h1);

        assign target[ch] = (sum_q > max_q) ? vmp_pkg::GAIN_MAX_Q : // R14
                            (sum_q < min_q) ? vmp_pkg::GAIN_MIN_Q : sum_q[9:0];
        assign o_chan_gain[ch] = gain_reg[ch];

        // A fresh value outranks a zero-cross in the same cycle and restarts the wait.
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                last_reg[ch] <= '0;
                pend_reg[ch] <= '0;
                gain_reg[ch] <= '0;
                wait_reg[ch] <= 1'b0;
                tmr_reg[ch]  <= 32'h0;
            end else begin
                last_reg[ch] <= target[ch];
                tmr_reg[ch]  <= tmr_reg[ch] + 32'h1;
                if (mode_now_imm) begin
                    gain_reg[ch] <= target[ch]; // R1
                    wait_reg[ch] <= 1'b0;
                end else if (new_val) begin
                    if (wait_reg[ch] && mode_now_flush) begin
                        gain_reg[ch] <= pend_reg[ch]; // R4
                    end
                    pend_reg[ch] <= target[ch]; // R3
                    wait_reg[ch] <= 1'b1;
                    tmr_reg[ch]  <= 32'h0;
                end else if (wait_reg[ch] && (i_zero_cross[ch] || expired)) begin
                    gain_reg[ch] <= pend_reg[ch]; // R2
                    wait_reg[ch] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on channel 0 and the register bank.

    imm_apply_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
        mode_now_imm |=> (gain_reg[0] == $past(target[0])))
        else $error("immediate mode did not apply level");
    zc_apply_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
        (!mode_now_imm && wait_reg[0] && i_zero_cross[0] && !g_ch[0].new_val)
        |=> (gain_reg[0] == $past(pend_reg[0])) && !wait_reg[0])
        else $error("pending level not applied on zero cross");
    discard_old_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
        (!mode_now_imm && !mode_now_flush && wait_reg[0] && g_ch[0].new_val)
        |=> $stable(gain_reg[0]) && wait_reg[0] && (tmr_reg[0] == 32'h0))
        else $error("discard mode changed level on new value");
    flush_old_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
        (mode_now_flush && wait_reg[0] && g_ch[0].new_val)
        |=> (gain_reg[0] == $past(pend_reg[0])) && (pend_reg[0] == $past(target[0])))
        else $error("flush mode did not apply older level");
    rsv_bits_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5 R18
        ((cfg2_reg & ~vmp_pkg::MASK_CFG2) == 8'h00) &&
        ((m1_ctrl_reg & ~vmp_pkg::MASK_M1_CTRL) == 8'h00))
        else $error("reserved bits stored");
    global_pd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
        act_reg.global_pd |=> (o_chan_pd == '1))
        else $error("global power down not applied");
    pd_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
        (act_reg.global_pd && wr_m1lvl) |=> (m1_level_reg == $past(i_wr_data)))
        else $error("write lost during power down");
    hold_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
        (hold_on && $past(hold_on)) |-> $stable(act_reg))
        else $error("held change took effect");
    gain_clamp_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
        (gain_reg[0] <= vmp_pkg::GAIN_MAX_Q) && (gain_reg[0] >= vmp_pkg::GAIN_MIN_Q))
        else $error("channel gain outside range");
    silence_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
        (act_reg.m1_silence && act_reg.m1_sel[0]) |=> o_chan_mute[0])
        else $error("selected channel not muted");
    timeout_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
        (g_ch[0].expired && !mode_now_imm && !g_ch[0].new_val) |=> !wait_reg[0])
        else $error("time-out did not apply level");

    // Pending levels, output stage and read path; these catch a pending change that leaks
    // out early and a channel power-down register that reads back something other than what it stores.
    pend_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
        (!mode_now_imm && wait_reg[0] && !i_zero_cross[0] && !g_ch[0].expired
            && !g_ch[0].new_val) |=> $stable(gain_reg[0]) && wait_reg[0])
        else $error("pending level applied without zero cross or time-out");
    imm_no_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
        mode_now_imm |=> !wait_reg[0])
        else $error("immediate mode left a level pending");
    pd_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
        !act_reg.global_pd |=> (o_chan_pd == $past(act_reg.chan_pd)))
        else $error("channel power down does not follow its bit");
    mute_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
        !act_reg.m1_silence |=> (o_chan_mute == '0))
        else $error("mute not released");
    hold_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
        !hold_on |=> (act_reg == $past(ctrl_now)))
        else $error("register change not acted upon with hold clear");
    rsv_ctrl_bits_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
        ((hold_reg & ~vmp_pkg::MASK_HOLD) == 8'h00) &&
        ((global_pd_reg & ~vmp_pkg::MASK_GLOBAL_PD) == 8'h00))
        else $error("reserved control bits stored");
    chan_pd_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
        (i_rd_en && (i_addr == vmp_pkg::ADDR_CHAN_PD)) |=> (o_rd_data == $past(chan_pd_reg)))
        else $error("channel power register read back wrong");
    unmapped_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
        (i_rd_en && (i_addr > vmp_pkg::ADDR_M2_LEVEL)) |=> (o_rd_data == 8'h00))
        else $error("unmapped offset did not read zero");

endmodule

// >>> sim/vmp_host_model.sv
// Host-side model of the control port that issues single register writes and reads.
`timescale 1ns/1ps

module vmp_host_model (
    // Clock.
    input  wire logic       i_clk,
    // Register port towards the bank.
    input  wire logic [7:0] i_rd_data,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wr_data
);
    // Idle bus at time zero.
    initial begin
        o_wr_en   = 1'b0;
        o_rd_en   = 1'b0;
        o_addr    = 8'h00;
        o_wr_data = 8'h00;
    end

    // One write held for a single sampling edge; data is inverted afterwards so stale values
    // never look valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr_en   <= 1'b1;
        o_addr    <= a;
        o_wr_data <= d;
        @(posedge i_clk);
        o_wr_en   <= 1'b0;
        o_wr_data <= ~d;
    endtask

    // One read; the data is taken one edge after the strobe was sampled.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd_en <= 1'b1;
        o_addr  <= a;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        @(posedge i_clk);
        #1;
        d = i_rd_data;
    endtask
endmodule

// >>> sim/vmp_bank_tb.sv
// Self-checking testbench for the master volume, power-down and update-hold bank.
`timescale 1ns/1ps

module vmp_bank_tb;
    // Short millisecond so that time-outs run 50 to 500 cycles.
    localparam int         CPM = 10;
    localparam logic [7:0] RST_TBL [10] = '{8'h0d, 8'h00, 8'h01, 8'h00, 8'hff, 8'hd2, 8'h00,
                                           8'hff, 8'hd2, 8'h00};
    logic            i_clk;
    logic            i_rst_n;
    logic            wr_en;
    logic            rd_en;
    logic [7:0]      addr;
    logic [7:0]      wr_data;
    logic [7:0]      rd_data;
    logic [7:0][7:0] chan_level;
    logic [7:0]      zero_cross;
    logic [7:0][9:0] chan_gain;
    logic [7:0]      chan_mute;
    logic [7:0]      chan_pd;
    int              fail_count = 0;
    int              total_checks = 0;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Design and host model.
    vmp_bank #(.NUM_CH(8), .P_CYC_PER_MS(CPM)) vmp_bank_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wr_data(wr_data), .o_rd_data(rd_data), .i_chan_level(chan_level),
        .i_zero_cross(zero_cross), .o_chan_gain(chan_gain), .o_chan_mute(chan_mute),
        .o_chan_pd(chan_pd));
    vmp_host_model vmp_host_model_inst (
        .i_clk(i_clk), .i_rd_data(rd_data), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wr_data(wr_data));

    // Clock at 25 MHz.
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Shared helpers.
    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        vmp_host_model_inst.rd(a, d);
        chk($sformatf("reg %h", a), {2'h0, exp}, {2'h0, d});
    endtask

    // A write reaches the outputs two edges after it is taken; one spare edge is allowed.
    task automatic wrw(input logic [7:0] a, input logic [7:0] d);
        vmp_host_model_inst.wr(a, d);
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    task automatic zc_pulse(input logic [7:0] m);
        @(posedge i_clk);
        zero_cross <= m;
        @(posedge i_clk);
        zero_cross <= 8'h00;
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset();
        for (int i = 0; i < 10; i++) rdchk(8'h0c + 8'(i), RST_TBL[i]);
        chk("pd", 10'h0ff, {2'h0, chan_pd});
        chk("mute", 10'h000, {2'h0, chan_mute});
        chk("gain0", 10'h000, chan_gain[0]);
    endtask

    // Reserved bits drop; 0c keeps mode 00 so no reserved mode code is written.
    task automatic t_reserved();
        wrw(8'h0c, 8'hfc);
        rdchk(8'h0c, 8'h1c);
        wrw(8'h0e, 8'hfe);
        rdchk(8'h0e, 8'h00);
        wrw(8'h0f, 8'h7f);
        rdchk(8'h0f, 8'h00);
        wrw(8'h12, 8'hfc);
        rdchk(8'h12, 8'h00);
        wrw(8'h15, 8'haa);
        rdchk(8'h15, 8'h00);
        wrw(8'h0c, 8'h0c);
    endtask

    task automatic t_power();
        wrw(8'h0d, 8'h05);
        chk("pd", 10'h005, {2'h0, chan_pd});
        wrw(8'h0e, 8'h01);
        chk("pd", 10'h0ff, {2'h0, chan_pd});
        wrw(8'h11, 8'hd4);
        rdchk(8'h11, 8'hd4);
        wrw(8'h0d, 8'h30);
        rdchk(8'h0d, 8'h30);
        wrw(8'h0d, 8'h00);
        wrw(8'h0e, 8'h00);
        chk("pd", 10'h000, {2'h0, chan_pd});
    endtask

    task automatic t_levels();
        wrw(8'h11, 8'hd4);
        chk("gain0", 10'h004, chan_gain[0]);
        wrw(8'h12, 8'h01);
        chk("gain0", 10'h005, chan_gain[0]);
        wrw(8'h12, 8'h02);
        chk("mute", 10'h0ff, {2'h0, chan_mute});
        wrw(8'h10, 8'h0f);
        chk("mute", 10'h00f, {2'h0, chan_mute});
        chk("gain4", 10'h000, chan_gain[4]);
        wrw(8'h10, 8'hff);
        wrw(8'h12, 8'h00);
        chk("mute", 10'h000, {2'h0, chan_mute});
        wrw(8'h13, 8'h01);
        wrw(8'h14, 8'hd4);
        chk("gain0", 10'h008, chan_gain[0]);
        chk("gain1", 10'h004, chan_gain[1]);
        wrw(8'h14, 8'hd2);
        wrw(8'h13, 8'hff);
        wrw(8'h11, 8'hff);
        chk("gain0", 10'h058, chan_gain[0]);
        wrw(8'h11, 8'h00);
        chk("gain0", 10'h280, chan_gain[0]);
        wrw(8'h11, 8'hd4);
        // Own levels add to the master level before the clamp.
        @(posedge i_clk);
        chan_level[2] <= 8'hd6;
        chan_level[3] <= 8'hfe;
        repeat (3) @(posedge i_clk);
        #1;
        chk("gain2", 10'h00c, chan_gain[2]);
        chk("gain3", 10'h058, chan_gain[3]);
        @(posedge i_clk);
        chan_level <= {8{8'hd2}};
    endtask

    task automatic t_hold();
        wrw(8'h0f, 8'h80);
        wrw(8'h11, 8'hd6);
        chk("gain0", 10'h004, chan_gain[0]);
        rdchk(8'h11, 8'hd6);
        wrw(8'h0f, 8'h00);
        chk("gain0", 10'h008, chan_gain[0]);
    endtask

    // Mode 01 then 10 with a 5 ms time-out of 50 cycles.
    task automatic t_zc();
        wrw(8'h0c, 8'h01);
        wrw(8'h11, 8'hd8);
        chk("gain0", 10'h008, chan_gain[0]);
        zc_pulse(8'h01);
        chk("gain0", 10'h00c, chan_gain[0]);
        chk("gain1", 10'h008, chan_gain[1]);
        repeat (60) @(posedge i_clk);
        #1;
        chk("gain1", 10'h00c, chan_gain[1]);
        wrw(8'h11, 8'hda);
        wrw(8'h11, 8'hdc);
        chk("gain0", 10'h00c, chan_gain[0]);
        zc_pulse(8'h01);
        chk("gain0", 10'h014, chan_gain[0]);
        repeat (60) @(posedge i_clk);
        wrw(8'h0c, 8'h02);
        wrw(8'h11, 8'hd4);
        chk("gain0", 10'h014, chan_gain[0]);
        wrw(8'h11, 8'hd6);
        chk("gain0", 10'h004, chan_gain[0]);
        zc_pulse(8'h01);
        chk("gain0", 10'h008, chan_gain[0]);
    endtask

    // Mode 01 with a 10 ms time-out of 100 cycles and no zero-crossing on channel 0.
    task automatic t_timeout();
        wrw(8'h0c, 8'h05);
        wrw(8'h11, 8'hd8);
        repeat (90) @(posedge i_clk);
        #1;
        chk("gain0", 10'h008, chan_gain[0]);
        repeat (15) @(posedge i_clk);
        #1;
        chk("gain0", 10'h00c, chan_gain[0]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Reset for three cycles, then run every scenario.
    initial begin
        i_rst_n    = 1'b0;
        chan_level = {8{8'hd2}};
        zero_cross = 8'h00;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1;
        t_reset();
        t_reserved();
        t_power();
        t_levels();
        t_hold();
        t_zc();
        t_timeout();
        summarize();
    end

    // Watchdog well beyond the roughly five hundred cycles the scenarios need.
    initial begin
        repeat (5000) @(posedge i_clk);
        fail_count++;
        summarize();
    end
endmodule
